/* verif/host_port_model.sv */
/*
  Host serial port model: frames words MSB first, samples the echo.
  Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/10ps
module host_port_model
#(
  parameter int HALF = 6
)
(
  // Clock
  input wire logic clk,
  // Pins toward the port
  output logic sck,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // Line as the host sees it: a released output reads the pull-up level
  wire logic line_out = serial_out_oe ? serial_out : 1'b1;

  // Idle levels
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end

  // One frame; echo taken at the end of each high phase
  task automatic send_word(input logic [15:0] w, input int nbits, output logic [15:0] echo, output logic oe_ok);
    echo = 16'h0000;
    oe_ok = 1'b1;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int k = 0; k < nbits; k++)
    begin
      serial_in = w[15 - k];
      repeat (2) @(negedge clk);
      sck = 1'b1;
      repeat (HALF) @(negedge clk);
      echo[15 - k] = line_out;
      oe_ok = oe_ok & serial_out_oe;
      sck = 1'b0;
      repeat (HALF) @(negedge clk);
    end
    cs_n = 1'b1;
    serial_in = ~serial_in; // No stale bit once released
    repeat (8) @(negedge clk);
  endtask

  // Serial clock and data wiggle while deselected
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      repeat (HALF) @(negedge clk);
      sck = ~sck;
      serial_in = ~serial_in;
    end
  endtask
endmodule

/* verif/testbench.sv */
/*
  Self-checking bench of the serial load port against a queue-based model.
  Assumes the host model drives the pins; strobe and reset driven here.
*/
`timescale 1ns/10ps
module testbench;
  import dac_port_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic strobe_n = 1'b1;
  wire logic sck;
  wire logic cs_n;
  wire logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic ready;
  logic [47:0] conv_data;
  int err_total = 0;
  int total_checks = 0;
  int inp[4];
  int conv[4];
  logic rise_mode = 1'b0;
  // Shift register model, oldest bit at the front
  bit shift_q[$];
  logic [15:0] frozen_echo;
  logic frozen_oe;

  quad_dac_serial_load_port i_dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .SCK(sck), .CS_N(cs_n),
    .SERIAL_IN(serial_in), .LOAD_ALL_STROBE_N(strobe_n), .SERIAL_OUT(serial_out),
    .SERIAL_OUT_OE(serial_out_oe), .CONV_DATA(conv_data), .PORT_READY(ready));
  host_port_model i_host (.clk(clock), .sck(sck), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [47:0] conv_exp();
    return {conv[3][11:0], conv[2][11:0], conv[1][11:0], conv[0][11:0]};
  endfunction

  // Frame plus model update; short frames leave registers alone
  task automatic frame(input logic [15:0] w, input int nbits);
    logic [15:0] echo;
    logic oe_ok;
    logic [15:0] exp_echo;
    int a;
    exp_echo = 16'h0000;
    a = w[15:14];
    // Falling mode shows the stage before the shift, rising mode after it
    for (int k = 0; k < nbits; k++)
    begin
      if (!rise_mode)
        exp_echo[15 - k] = shift_q[0];
      shift_q.push_back(w[15 - k]);
      void'(shift_q.pop_front());
      if (rise_mode)
        exp_echo[15 - k] = shift_q[0];
    end
    i_host.send_word(w, nbits, echo, oe_ok);
    check({47'h0, oe_ok}, 48'h1);
    check({46'h0, serial_out_oe, serial_out}, 48'h1);
    if (nbits == 16)
    begin
      check({32'h0, echo}, {32'h0, exp_echo});
      if (w[13:12] != 2'h3)
        inp[a] = w[11:0];
      if (w[13:12] == 2'h1)
        conv[a] = w[11:0];
      if (w[13:12] == 2'h2 || w[15:12] == 4'hB)
        conv = inp;
      if (w[15:12] == 4'h3 || w[15:12] == 4'h7)
        rise_mode = w[14];
      if (strobe_n == 1'b0)
        conv = inp;
    end
    check(conv_data, conv_exp());
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h8bf6));
    repeat (16) shift_q.push_back(1'b0);
    repeat (16) @(negedge clock);
    check({45'h0, serial_out, serial_out_oe, ready}, 48'h4);
    check(conv_data, 48'h0);
    rst_n = 1'b1;
    repeat (1990) @(negedge clock);
    check({47'h0, ready}, 48'h0);
    repeat (20) @(negedge clock);
    check({47'h0, ready}, 48'h1);
    // Every address and control code once
    for (int c = 0; c < 16; c++)
      frame({c[3:0], 12'($urandom())}, 16);
    i_host.idle_clocks(16);
    frame(16'($urandom()), 8);
    // Clock enable low: a whole word is ignored and nothing moves
    ce = 1'b0;
    i_host.send_word(16'($urandom()), 16, frozen_echo, frozen_oe);
    ce = 1'b1;
    check(conv_data, conv_exp());
    check({46'h0, serial_out_oe, serial_out}, 48'h1);
    for (int i = 0; i < 30; i++)
      frame(16'($urandom()), 16);
    @(negedge clock);
    strobe_n = 1'b0;
    repeat (6) @(negedge clock);
    conv = inp;
    check(conv_data, conv_exp());
    for (int i = 0; i < 4; i++)
      frame({i[1:0], 2'h0, 12'($urandom())}, 16);
    strobe_n = 1'b1;
    frame(16'($urandom()), 16);
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    stop_test();
  end
endmodule

/* verilog/dac_port_defs.svh */
/*
  Constants of the quad converter serial load port: word layout, reset values
  and timing counts. Assumes a 40 MHz system clock on CLOCK.
*/
`ifndef DAC_PORT_DEFS_SVH
`define DAC_PORT_DEFS_SVH

// Word layout, most significant bit first on the wire
`define WORD_BITS 16
`define DATA_BITS 12
`define ADDR_HI_POS 15
`define ADDR_LO_POS 14
`define CTRL_HI_POS 13
`define CTRL_LO_POS 12
`define DATA_MSB 11
`define CHANNELS 4

// Bit counter saturates at a full word
`define BIT_CNT_W 5
`define BIT_CNT_FULL 5'h10

// Reset values
`define SHIFT_RESET 16'h0000
`define DATA_RESET 12'h000
`define EDGE_RISE_RESET 1'b0
// Pin order {load strobe, serial in, chip select, serial clock}: idle levels
`define PIN_RESET 4'hA

// Internal power-on pulse: longest time, rounded down to whole cycles
`define CLK_PERIOD_PS 25000
`define POR_TIME_PS 50000000
`define POR_CYCLES (`POR_TIME_PS / `CLK_PERIOD_PS)
`define POR_CNT_W 11

`endif

/* verilog/dac_port_pkg.sv */
/*
  Types shared by the serial load port modules.
  Assumes dac_port_defs.svh supplies the numeric constants.
*/
package dac_port_pkg;

  // Actions that a committed word can request
  typedef enum logic [2:0] {
    CMD_LOAD_INPUT,
    CMD_LOAD_BOTH,
    CMD_LOAD_UPD_ALL,
    CMD_EDGE_FALL,
    CMD_EDGE_RISE,
    CMD_UPD_ALL,
    CMD_NOP
  } cmd_t;

  // Port sequencing
  typedef enum logic [1:0] {
    ST_POR,
    ST_IDLE,
    ST_SHIFT
  } port_state_t;

  typedef logic [11:0] sample_t;

endpackage

/* verilog/pin_events_if.sv */
/*
  Synchronised pin levels and edge pulses passed from the pin sampler to the
  port logic. Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface pin_events_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic serial_in;
  logic load_all_low;

  modport src (output sck_rise, sck_fall, cs_low, cs_fall, cs_rise, serial_in, load_all_low);
  modport snk (input sck_rise, sck_fall, cs_low, cs_fall, cs_rise, serial_in, load_all_low);
endinterface

/* verilog/pin_sampler.sv */
/*
  Two-stage synchronisers for the four serial port pins and edge detection
  on the synchronised serial clock and chip select.
  Assumes pins are asynchronous to clk and slower than clk/4.
*/
`timescale 1ns/10ps
`include "dac_port_defs.svh"
module pin_sampler
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw pins
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic serial_in_pin,
  input wire logic load_all_n_pin,
  // Events toward the port logic
  pin_events_if.src ev
);

  logic [3:0] raw;
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;
  // Idle pin levels, one bit per stage lane
  localparam logic [3:0] pin_idle = `PIN_RESET;

  assign raw = {load_all_n_pin, serial_in_pin, cs_n_pin, sck_pin};

  // One synchroniser per pin; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r[g] <= pin_idle[g];
          sync_r[g] <= pin_idle[g];
          prev_r[g] <= pin_idle[g];
        end
        else if (ce)
        begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  // Edges are taken from the settled stages only
  assign ev.sck_rise = sync_r[0] & ~prev_r[0];
  assign ev.sck_fall = ~sync_r[0] & prev_r[0];
  assign ev.cs_low = ~sync_r[1];
  assign ev.cs_fall = ~sync_r[1] & prev_r[1];
  assign ev.cs_rise = sync_r[1] & ~prev_r[1];
  assign ev.serial_in = sync_r[2];
  assign ev.load_all_low = ~sync_r[3];

  // Settled levels follow the first stage by one enabled cycle
  sync_stage_a: assert property (@(posedge clk) disable iff (!rst_n) ce |=> sync_r == $past(meta_r))
    else $error("synchroniser second stage did not follow first");

endmodule

/* verilog/quad_dac_serial_load_port.sv */
/*
  Serial load port of a quad 12-bit converter: shift register, word commit,
  input and converter registers, load strobe, serial echo, power-on reset.
  Assumes all pins are asynchronous to CLOCK and run well below CLOCK/4.
*/
`timescale 1ns/10ps
`include "dac_port_defs.svh"
module quad_dac_serial_load_port
  import dac_port_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial port pins
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  input wire logic LOAD_ALL_STROBE_N,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE,
  // Converter register contents, channel 0 in the low bits
  output logic [47:0] CONV_DATA,
  // Status
  output logic PORT_READY
);

  pin_events_if ev ();

  pin_sampler u_pins
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .sck_pin(SCK),
    .cs_n_pin(CS_N),
    .serial_in_pin(SERIAL_IN),
    .load_all_n_pin(LOAD_ALL_STROBE_N),
    .ev(ev)
  );

  // Fixed command table
  function automatic cmd_t cmd_of(input logic [3:0] code);
    cmd_t c;
    c = CMD_NOP;
    unique case (code[1:0])
      2'h0: c = CMD_LOAD_INPUT;
      2'h1: c = CMD_LOAD_BOTH;
      2'h2: c = CMD_LOAD_UPD_ALL;
      2'h3:
        unique case (code[3:2])
          2'h0: c = CMD_EDGE_FALL;
          2'h1: c = CMD_EDGE_RISE;
          2'h2: c = CMD_UPD_ALL;
          2'h3: c = CMD_NOP;
        endcase
    endcase
    return c;
  endfunction

  port_state_t state_r, state_nxt;
  logic [`POR_CNT_W-1:0] por_cnt_r;
  logic [`WORD_BITS-1:0] shift_r, shift_nxt;
  logic [`BIT_CNT_W-1:0] bit_cnt_r;
  logic edge_rise_r;
  logic ready_r;
  logic serial_out_r;
  logic serial_oe_r;
  sample_t in_r [`CHANNELS];
  sample_t conv_r [`CHANNELS];
  sample_t in_nxt [`CHANNELS];
  sample_t conv_nxt [`CHANNELS];
  logic [47:0] in_flat;

  // Word fields and decode
  wire ce_ok = CE;
  wire shifting = ce_ok && state_r == ST_SHIFT;
  wire por_done = por_cnt_r == `POR_CNT_W'(`POR_CYCLES - 1);
  wire word_full = bit_cnt_r == `BIT_CNT_FULL;
  wire [1:0] word_addr = {shift_r[`ADDR_HI_POS], shift_r[`ADDR_LO_POS]};
  wire [1:0] word_ctrl = {shift_r[`CTRL_HI_POS], shift_r[`CTRL_LO_POS]};
  wire sample_t word_data = shift_r[`DATA_MSB:0];
  wire cmd_t cmd_w = cmd_of({word_addr, word_ctrl});
  // Short words are dropped: a host that lifts chip select early gets nothing
  wire commit = shifting && ev.cs_rise && word_full;
  wire load_in = commit && (cmd_w == CMD_LOAD_INPUT || cmd_w == CMD_LOAD_BOTH || cmd_w == CMD_LOAD_UPD_ALL);
  wire load_conv_one = commit && cmd_w == CMD_LOAD_BOTH;
  wire copy_all = ev.load_all_low || (commit && (cmd_w == CMD_LOAD_UPD_ALL || cmd_w == CMD_UPD_ALL));
  wire sck_shift = shifting && ev.cs_low && ev.sck_rise;

  // Next shift value: new bit enters at the bottom
  assign shift_nxt = sck_shift ? {shift_r[`WORD_BITS-2:0], ev.serial_in} : shift_r;

  // State sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POR: if (por_done) state_nxt = ST_IDLE;
      ST_IDLE: if (ev.cs_fall) state_nxt = ST_SHIFT;
      ST_SHIFT: if (ev.cs_rise) state_nxt = ST_IDLE;
      default: state_nxt = ST_POR; // Unused code: back to ST_POR, left on the next cycle because the counter keeps its end count
    endcase
  end

  // Power-on pulse counter, then the port opens
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= ST_POR;
      por_cnt_r <= '0;
      ready_r <= 1'b0;
    end
    else if (CE)
    begin
      state_r <= state_nxt;
      if (state_r == ST_POR && !por_done)
        por_cnt_r <= por_cnt_r + `POR_CNT_W'(1);
      ready_r <= state_nxt != ST_POR;
    end
  end

  // Shift register and saturating bit count; a new frame restarts the count
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      shift_r <= `SHIFT_RESET;
      bit_cnt_r <= '0;
    end
    else if (CE)
    begin
      shift_r <= shift_nxt;
      if (state_r == ST_IDLE && ev.cs_fall)
        bit_cnt_r <= '0;
      else if (sck_shift && !word_full)
        bit_cnt_r <= bit_cnt_r + `BIT_CNT_W'(1);
    end
  end

  // Serial output edge setting
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      edge_rise_r <= `EDGE_RISE_RESET;
    else if (CE && commit && cmd_w == CMD_EDGE_FALL)
      edge_rise_r <= 1'b0;
    else if (CE && commit && cmd_w == CMD_EDGE_RISE)
      edge_rise_r <= 1'b1;
  end

  // Per-channel input and converter registers
  genvar g;
  generate
    for (g = 0; g < `CHANNELS; g++)
    begin : g_chan
      // Copy from the new input value so a strobe held low passes updates at once
      assign in_nxt[g] = (load_in && word_addr == 2'(g)) ? word_data : in_r[g];
      assign conv_nxt[g] = copy_all ? in_nxt[g] :
                           ((load_conv_one && word_addr == 2'(g)) ? word_data : conv_r[g]);
      assign CONV_DATA[12*g+11:12*g] = conv_r[g];
      assign in_flat[12*g+11:12*g] = in_r[g];

      always_ff @(posedge CLOCK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          in_r[g] <= `DATA_RESET;
          conv_r[g] <= `DATA_RESET;
        end
        else if (CE)
        begin
          in_r[g] <= in_nxt[g];
          conv_r[g] <= conv_nxt[g];
        end
      end
    end
  endgenerate

  // Serial echo: idles high undriven; MSB stage shown on the chosen edge
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      serial_out_r <= 1'b1;
      serial_oe_r <= 1'b0;
    end
    else if (CE)
    begin
      if (!ev.cs_low || state_r == ST_POR)
      begin
        serial_out_r <= 1'b1;
        serial_oe_r <= 1'b0;
      end
      else if (ev.cs_fall)
      begin
        serial_out_r <= shift_r[`WORD_BITS-1];
        serial_oe_r <= 1'b1;
      end
      else if (edge_rise_r ? ev.sck_rise : ev.sck_fall)
        serial_out_r <= shift_nxt[`WORD_BITS-1];
    end
  end

  assign SERIAL_OUT = serial_out_r;
  assign SERIAL_OUT_OE = serial_oe_r;
  assign PORT_READY = ready_r;

  shift_in_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    sck_shift |=> shift_r == {$past(shift_r[`WORD_BITS-2:0]), $past(ev.serial_in)})
    else $error("serial bit not shifted in");

  hold_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_r != ST_SHIFT) |=> shift_r == $past(shift_r))
    else $error("shift register moved outside a frame");

  commit_both_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (commit && cmd_w == CMD_LOAD_BOTH && !ev.load_all_low) |=> conv_r[$past(word_addr)] == $past(word_data))
    else $error("converter register not loaded on commit");

  strobe_copy_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CE && ev.load_all_low) |=> CONV_DATA == in_flat)
    else $error("load strobe did not copy input registers");

  out_pullup_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CE && !ev.cs_low) |=> (SERIAL_OUT && !SERIAL_OUT_OE))
    else $error("serial out not idle high with chip select high");

  out_edge_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CE && ev.cs_low && !ev.cs_fall && state_r != ST_POR && (edge_rise_r ? ev.sck_rise : ev.sck_fall))
    |=> SERIAL_OUT == $past(shift_nxt[`WORD_BITS-1]))
    else $error("serial out not updated on selected edge");

  por_end_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CE && state_r == ST_POR && por_done) |=> (state_r == ST_IDLE && PORT_READY))
    else $error("power-on pulse not ended at its count");

  por_bound_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    por_cnt_r <= `POR_CNT_W'(`POR_CYCLES - 1))
    else $error("power-on counter ran past its limit");

  edge_cmd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (commit && cmd_w == CMD_EDGE_RISE) |=> edge_rise_r ##1 edge_rise_r || !CE)
    else $error("edge setting not taken from command");

  transparent_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (load_in && ev.load_all_low) |=> conv_r[$past(word_addr)] == $past(word_data))
    else $error("input update did not pass through with strobe low");

endmodule
